/* include/iss_map.vh */
`ifndef ISS_MAP_VH
`define ISS_MAP_VH
// frame length in serial clocks
`define ISS_FRAME_BITS 32
`define ISS_CNT_W 6
// response word layout: data in upper half, echo of command in lower half
`define ISS_RESP_DATA_MSB 31
`define ISS_RESP_DATA_LSB 16
`define ISS_CMD_MSB 15
`define ISS_CMD_LSB 0
// reset values
`define ISS_RESP_RST 32'h00000000
`define ISS_CNT_RST 6'h00
// fifo depth and width
`define ISS_FIFO_DEPTH 8
`define ISS_FIFO_AW 3
`define ISS_WORD_W 32
`endif

/* rtl/iss_fifo.v */
`timescale 1ns/1ps
module iss_fifo #(
   parameter WIDTH = 32,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   input wire clk,
   input wire rst,
   input wire [WIDTH-1:0] in_data,
   input wire in_valid,
   output wire in_ready,
   output wire [WIDTH-1:0] out_data,
   output wire out_valid,
   input wire out_ready
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0] wr_ptr_reg;
   reg [AW:0] rd_ptr_reg;
   wire full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
   wire empty = (wr_ptr_reg == rd_ptr_reg);
   wire do_wr = in_valid && !full;
   wire do_rd = out_ready && !empty;
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem[rd_ptr_reg[AW-1:0]];
   // storage write
   always @(posedge clk) begin
      if (do_wr) begin
         mem[wr_ptr_reg[AW-1:0]] <= in_data;
      end
   end
   // pointers
   always @(posedge clk) begin
      if (rst) begin
         wr_ptr_reg <= {(AW+1){1'b0}};
         rd_ptr_reg <= {(AW+1){1'b0}};
      end else begin
         if (do_wr) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (do_rd) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
      end
   end
endmodule

/* rtl/iss_spi_slave.v */
`timescale 1ns/1ps
`include "iss_map.vh"
module iss_spi_slave (
   clk,
   rst,
   sclk,
   select_n,
   mosi,
   miso_o,
   miso_oe,
   cmd_data,
   cmd_valid,
   cmd_ready,
   resp_data,
   resp_valid,
   resp_ready,
   frame_err
);
   input wire clk;
   input wire rst;
   input wire sclk;
   input wire select_n;
   input wire mosi;
   output reg miso_o;
   output reg miso_oe;
   output wire [`ISS_WORD_W-1:0] cmd_data;
   output wire cmd_valid;
   input wire cmd_ready;
   input wire [15:0] resp_data;
   input wire resp_valid;
   output reg resp_ready;
   output reg frame_err;

   // two-stage synchronisers for pins
   reg [1:0] sclk_sync_reg;
   reg [1:0] csn_sync_reg;
   reg [1:0] mosi_sync_reg;
   reg sclk_d_reg;
   reg csn_d_reg;
   always @(posedge clk) begin
      if (rst) begin
         sclk_sync_reg <= 2'h0;
         csn_sync_reg <= 2'h3;
         mosi_sync_reg <= 2'h0;
         sclk_d_reg <= 1'b0;
         csn_d_reg <= 1'b1;
      end else begin
         sclk_sync_reg <= {sclk_sync_reg[0], sclk};
         csn_sync_reg <= {csn_sync_reg[0], select_n};
         mosi_sync_reg <= {mosi_sync_reg[0], mosi};
         sclk_d_reg <= sclk_sync_reg[1];
         csn_d_reg <= csn_sync_reg[1];
      end
   end

   wire sclk_s = sclk_sync_reg[1];
   wire csn_s = csn_sync_reg[1];
   wire mosi_s = mosi_sync_reg[1];
   wire active = !csn_s;
   wire sclk_rise = active && sclk_s && !sclk_d_reg;
   wire sclk_fall = active && !sclk_s && sclk_d_reg;
   wire cs_fall = !csn_s && csn_d_reg;
   wire cs_rise = csn_s && !csn_d_reg;

   // frame state
   reg [`ISS_CNT_W-1:0] cnt_reg;
   reg [`ISS_WORD_W-1:0] rx_reg;
   reg [`ISS_WORD_W-1:0] tx_reg;
   reg [`ISS_WORD_W-1:0] resp_word_reg;
   reg push_reg;
   reg [`ISS_WORD_W-1:0] push_data_reg;

   // next response: 16-bit result above, echo of last command below
   wire [15:0] result = resp_valid ? resp_data : 16'h0000;

   // receive shifter and bit counter
   always @(posedge clk) begin
      if (rst) begin
         cnt_reg <= `ISS_CNT_RST;
         rx_reg <= `ISS_RESP_RST;
      end else if (cs_fall) begin
         cnt_reg <= `ISS_CNT_RST;
      end else if (sclk_rise) begin
         rx_reg <= {rx_reg[`ISS_WORD_W-2:0], mosi_s};
         if (cnt_reg != 6'h3F) begin
            cnt_reg <= cnt_reg + 6'h01;
         end
      end
   end

   // transmit shifter, loaded at frame start with the last complete frame's response
   always @(posedge clk) begin
      if (rst) begin
         tx_reg <= `ISS_RESP_RST;
         miso_o <= 1'b0;
         miso_oe <= 1'b0;
      end else begin
         miso_oe <= active;
         if (cs_fall) begin
            tx_reg <= {resp_word_reg[`ISS_WORD_W-2:0], 1'b0};
            miso_o <= resp_word_reg[`ISS_WORD_W-1];
         end else if (sclk_fall && cnt_reg != `ISS_CNT_RST) begin
            miso_o <= tx_reg[`ISS_WORD_W-1];
            tx_reg <= {tx_reg[`ISS_WORD_W-2:0], 1'b0};
         end else if (!active) begin
            miso_o <= 1'b0;
         end
      end
   end

   // end of frame: commit command and build next response
   always @(posedge clk) begin
      if (rst) begin
         resp_word_reg <= `ISS_RESP_RST;
         push_reg <= 1'b0;
         push_data_reg <= `ISS_RESP_RST;
         resp_ready <= 1'b0;
         frame_err <= 1'b0;
      end else begin
         resp_ready <= 1'b0;
         push_reg <= 1'b0; // one-cycle push; a full fifo drops it
         if (cs_rise) begin
            if (cnt_reg == `ISS_FRAME_BITS) begin
               frame_err <= 1'b0;
               push_reg <= 1'b1;
               push_data_reg <= rx_reg;
               resp_word_reg <= {result, rx_reg[`ISS_CMD_MSB:`ISS_CMD_LSB]};
               resp_ready <= resp_valid;
            end else begin
               frame_err <= 1'b1;
            end
         end
      end
   end

   // command buffer toward the core; full fifo drops extra frames
   iss_fifo #(
      .WIDTH(`ISS_WORD_W),
      .DEPTH(`ISS_FIFO_DEPTH),
      .AW(`ISS_FIFO_AW)
   ) iss_fifo_i (
      .clk(clk),
      .rst(rst),
      .in_data(push_data_reg),
      .in_valid(push_reg),
      .in_ready(),
      .out_data(cmd_data),
      .out_valid(cmd_valid),
      .out_ready(cmd_ready)
   );
endmodule

/* bench/iss_spi_slave_sva.sv */
`timescale 1ns/1ps
module iss_spi_slave_sva (
   input logic clk,
   input logic rst,
   input logic sclk,
   input logic select_n,
   input logic miso_o,
   input logic miso_oe,
   input logic cmd_valid,
   input logic resp_valid,
   input logic resp_ready,
   input logic frame_err
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // pin release, bit timing and end-of-frame effects
   oe_idle_a: assert property (select_n [*8] |-> !miso_oe) else $error("oe idle");
   oe_on_a: assert property ($fell(select_n) ##1 !select_n [*8] |-> miso_oe) else $error("oe late");
   oe_off_a: assert property ($rose(select_n) |-> ##[1:8] !miso_oe) else $error("oe stuck");
   miso_fall_a: assert property ($changed(miso_o) && miso_oe |-> !sclk) else $error("miso edge");
   resp_pulse_a: assert property (resp_ready |=> !resp_ready) else $error("pulse");
   resp_take_a: assert property (resp_ready |-> select_n && $past(resp_valid)) else $error("take");
   push_end_a: assert property ($rose(cmd_valid) |-> select_n) else $error("push");
   err_end_a: assert property ($changed(frame_err) |-> select_n) else $error("err");
   cover property (resp_ready);
   cover property ($rose(frame_err));
   cover property ($rose(cmd_valid));
endmodule
bind iss_spi_slave iss_spi_slave_sva iss_spi_slave_sva_i (.clk, .rst, .sclk, .select_n, .miso_o, .miso_oe,
   .cmd_valid, .resp_valid, .resp_ready, .frame_err);

/* bench/iss_host.sv */
`timescale 1ns/1ps
module iss_host (
   output logic sclk = 0,
   output logic select_n = 1,
   output logic mosi = 0,
   input logic miso_o,
   input logic miso_oe
);
   // one frame of n clocks, msb first; a released miso reads as the previous bit inverted
   task xfer(input logic [31:0] t, input int n, output logic [31:0] r);
      select_n = 0;
      for (int i = 0; i < n; i++) begin
         #24 sclk = 0;
         mosi = t[31 - i];
         #24 sclk = 1;
         r = {r[30:0], miso_oe ? miso_o : ~r[0]};
      end
      #24 sclk = 0;
      #24 select_n = 1;
      #200;
   endtask
endmodule

/* bench/inertial_sensor_spi_slave_test.sv */
`timescale 1ns/1ps
module inertial_sensor_spi_slave_test;
   logic clk = 0, rst = 1, cmd_ready = 0, resp_valid = 1;
   logic [15:0] resp_data = 16'hA5C3;
   logic sclk, select_n, mosi, miso_o, miso_oe, cmd_valid, resp_ready, frame_err;
   logic [31:0] cmd_data, rx, w;
   int err_total = 0, cmp_count = 0, pulses = 0;
   // count response-taken pulses
   always @(posedge clk) if (resp_ready === 1'b1) pulses++;
   iss_spi_slave iss_spi_slave_i (.clk, .rst, .sclk, .select_n, .mosi, .miso_o, .miso_oe, .cmd_data,
      .cmd_valid, .cmd_ready, .resp_data, .resp_valid, .resp_ready, .frame_err);
   iss_host iss_host_i (.sclk, .select_n, .mosi, .miso_o, .miso_oe);
   // clock
   always #2 clk = ~clk;
   task chk(input string n, input logic [31:0] e, g);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s exp %h got %h", n, e, g);
      end
   endtask
   task give_verdict();
      $display("%0d checks %0d mismatches", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // take the head word with a one-cycle ready
   task pop();
      repeat (50) if (!cmd_valid) @(posedge clk);
      w = cmd_data;
      @(posedge clk) #1 cmd_ready = 1;
      @(posedge clk) #1 cmd_ready = 0;
   endtask
   task t_frame();
      iss_host_i.xfer(32'h12348F01, 32, rx);
      @(posedge clk) #1 resp_data = 16'h7FFF;
      iss_host_i.xfer(32'hCAFE0F0F, 32, rx);
      chk("resp", 32'hA5C38F01, rx);
      pop();
      chk("cmd", 32'h12348F01, w);
      chk("pulse", 2, pulses);
      $display("t_frame end");
   endtask
   task t_short();
      pop();
      chk("cmd", 32'hCAFE0F0F, w);
      iss_host_i.xfer(32'h1111, 31, rx);
      chk("err", 1, frame_err);
      chk("valid", 0, cmd_valid);
      iss_host_i.xfer(32'h2222, 32, rx);
      chk("resp", 32'h7FFF0F0F, rx);
      chk("err", 0, frame_err);
      pop();
      chk("cmd", 32'h2222, w);
      $display("t_short end");
   endtask
   task t_fifo();
      @(posedge clk) #1 resp_valid = 0;
      for (int i = 0; i < 9; i++) iss_host_i.xfer(i, 32, rx);
      chk("resp", 32'h7, rx);
      for (int i = 0; i < 8; i++) begin
         pop();
         chk("cmd", i, w);
      end
      chk("valid", 0, cmd_valid);
      chk("pulse", 3, pulses);
      $display("t_fifo end");
   endtask
   // reset, then the scenarios
   initial begin
      repeat (6) @(posedge clk);
      #1 rst = 0;
      repeat (4) @(posedge clk);
      t_frame();
      t_short();
      t_fifo();
      give_verdict();
   end
   // watchdog
   initial begin
      #100000 err_total++;
      give_verdict();
   end
endmodule
